// ==== hw/pstc_top.sv ====
// power state sequencer with apb registers and interrupt
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pstc_map.svh"
// Overview of operation
// - reset into linear regulator, level zero
// - linear0 to switching1 passes linear1 first
// - core level moves both ways
// - level change keeps regulator type
// - regulator change keeps level
// - deep sleep only from linear regulator
// - preserved entry restores prior state on wake
// - direct deep sleep restores nothing
// - busy clocks hold off entry by default
// - forced mode halts busy clocks
// - unforced entry waits for clock release
// - four flags, all cleared together by a status read
// - per-flag enable gates the interrupt
module pstc_top (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        clk_request_busy,
	input  wire logic        wake_event,
	input  wire logic        regulator_fault,
	output logic             switching_regulator_select,
	output logic             core_level_one,
	output logic             deep_sleep_entry,
	output logic             light_sleep_entry,
	output logic             shutdown_entry,
	output logic             clock_halt,
	output logic             irq
);
	logic [3:0] flags;
	logic [3:0] mask;
	logic       forced_entry_on;
	logic       cur_sw;
	logic       cur_lvl;
	logic       tgt_sw;
	logic       tgt_lvl;
	logic       keep_sw;
	logic       keep_lvl;
	logic       keep_valid;
	logic       sleep_pending_keep;
	pstc_pkg::pstc_kind_t pend_kind;
	pstc_pkg::pstc_mode_t mode;
	pstc_step_if step ();

	pstc_step_timer u_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.step    (step)
	);

	// apb decode
	wire       acc       = psel && penable;
	wire       wr_acc    = acc && pwrite;
	wire       rd_acc    = acc && !pwrite;
	wire       hit_ctrl  = paddr == `PSTC_OFF_CTRL;
	wire       hit_req   = paddr == `PSTC_OFF_REQ;
	wire       hit_state = paddr == `PSTC_OFF_STATE;
	wire       hit_stat  = paddr == `PSTC_OFF_STATUS;
	wire       hit_mask  = paddr == `PSTC_OFF_MASK;
	wire       hit_mskd  = paddr == `PSTC_OFF_MASKED;
	wire       mapped    = hit_ctrl | hit_req | hit_state | hit_stat | hit_mask | hit_mskd;
	wire [2:0] req_kind  = pwdata[`PSTC_REQ_KIND_LSB +: 3];
	wire [1:0] req_arg   = pwdata[`PSTC_REQ_ARG_LSB +: 2];
	wire       req_new   = wr_acc && hit_req && pready == 1'b0;
	wire       status_rd = rd_acc && hit_stat && pready == 1'b0;

	// read mux; state word shows mode, level, regulator and keep state
	wire [31:0] rd_word =
		hit_ctrl  ? {31'h0, forced_entry_on} :
		hit_state ? {24'h0, 1'b0, mode, keep_valid, 1'b0, cur_sw, cur_lvl} :
		hit_stat  ? {28'h0, flags} :
		hit_mask  ? {28'h0, mask} :
		hit_mskd  ? {28'h0, flags & mask} :
		32'h0;

	// request classification
	wire in_active  = mode == pstc_pkg::PSTC_ACTIVE;
	wire is_state   = req_kind == 3'(pstc_pkg::PSTC_KIND_STATE);
	wire is_level   = req_kind == 3'(pstc_pkg::PSTC_KIND_LEVEL);
	wire is_reg     = req_kind == 3'(pstc_pkg::PSTC_KIND_REG);
	wire is_keep    = req_kind == 3'(pstc_pkg::PSTC_KIND_SLEEP_KEEP);
	wire is_direct  = req_kind == 3'(pstc_pkg::PSTC_KIND_SLEEP_DIRECT);
	wire is_light   = req_kind == 3'(pstc_pkg::PSTC_KIND_LIGHT);
	wire is_shut    = req_kind == 3'(pstc_pkg::PSTC_KIND_SHUTDOWN);
	wire is_active_req = is_state | is_level | is_reg;
	wire is_sleep_req  = is_keep | is_direct | is_light | is_shut;
	// direct deep sleep from switching is not a single legal step
	wire direct_bad = is_direct && cur_sw;
	wire bad_active = req_new && (!in_active || req_kind == 3'(pstc_pkg::PSTC_KIND_NONE)) && is_active_req;
	wire bad_sleep  = req_new && is_sleep_req && (!in_active || direct_bad);
	wire bad_kind   = req_new && req_kind == 3'(pstc_pkg::PSTC_KIND_NONE);
	wire accept     = req_new && in_active && !bad_kind && !direct_bad;
	// targets: level keeps regulator, regulator keeps level
	wire new_sw  = is_state ? req_arg[1] : is_reg ? req_arg[0] : cur_sw;
	wire new_lvl = is_state ? req_arg[0] : is_level ? req_arg[0] : cur_lvl;

	// stepping toward the target one field at a time
	wire need_lvl   = tgt_lvl != cur_lvl;
	wire need_sw    = tgt_sw != cur_sw;
	// level changes are made on the linear regulator when going up to switching or down from it
	wire lvl_first  = need_lvl && (!cur_sw || !need_sw);
	wire at_target  = !need_lvl && !need_sw;
	wire sleep_ok   = !clk_request_busy || forced_entry_on;
	wire sleep_kind = pend_kind != pstc_pkg::PSTC_KIND_NONE;
	wire flag_ev_act = bad_active | bad_kind;
	wire flag_ev_slp = bad_sleep;
	wire flag_ev_clk = mode == pstc_pkg::PSTC_WAIT_CLK && clk_request_busy && !forced_entry_on && req_new;
	wire [3:0] flag_set = {flag_ev_slp, flag_ev_clk, flag_ev_act, regulator_fault};
	wire [3:0] flag_clr = status_rd ? flags : 4'h0;

	// apb slave: one wait state, then ready for one cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !mapped;
			prdata  <= (rd_acc && !pready) ? rd_word : 32'h0;
		end
	end

	// control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			forced_entry_on <= 1'b0;
			mask            <= `PSTC_RST_MASK;
		end else if (wr_acc && !pready) begin
			if (hit_ctrl) forced_entry_on <= pwdata[`PSTC_CTRL_FORCED];
			if (hit_mask) mask <= pwdata[3:0];
		end
	end

	// sticky flags: read of status clears, a new event in that cycle wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flags <= 4'h0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode               <= pstc_pkg::PSTC_ACTIVE;
			cur_sw             <= 1'b0;
			cur_lvl            <= 1'b0;
			tgt_sw             <= 1'b0;
			tgt_lvl            <= 1'b0;
			keep_sw            <= 1'b0;
			keep_lvl           <= 1'b0;
			keep_valid         <= 1'b0;
			sleep_pending_keep <= 1'b0;
			pend_kind          <= pstc_pkg::PSTC_KIND_NONE;
			step.go            <= 1'b0;
		end else begin
			step.go <= 1'b0;
			unique case (mode)
				pstc_pkg::PSTC_ACTIVE: begin
					if (accept && is_active_req) begin
						tgt_sw  <= new_sw;
						tgt_lvl <= new_lvl;
						mode    <= pstc_pkg::PSTC_STEP;
						step.go <= 1'b1;
					end else if (accept && is_sleep_req) begin
						pend_kind <= pstc_pkg::pstc_kind_t'(req_kind);
						keep_valid <= is_keep;
						keep_sw    <= cur_sw;
						keep_lvl   <= cur_lvl;
						// deep sleep needs the linear regulator at the same level
						tgt_sw  <= is_keep ? 1'b0 : cur_sw;
						tgt_lvl <= cur_lvl;
						mode    <= pstc_pkg::PSTC_STEP;
						step.go <= 1'b1;
					end
				end
				pstc_pkg::PSTC_STEP: begin
					if (step.done) begin
						if (lvl_first) begin
							cur_lvl <= tgt_lvl;
						end else if (need_sw) begin
							cur_sw <= tgt_sw;
						end
						if ((lvl_first && need_sw) || (!lvl_first && need_sw && need_lvl)) begin
							step.go <= 1'b1;
						end else if (sleep_kind) begin
							mode <= pstc_pkg::PSTC_WAIT_CLK;
						end else begin
							mode <= pstc_pkg::PSTC_ACTIVE;
						end
					end else if (at_target) begin
						mode <= sleep_kind ? pstc_pkg::PSTC_WAIT_CLK : pstc_pkg::PSTC_ACTIVE;
					end
				end
				pstc_pkg::PSTC_WAIT_CLK: begin
					if (sleep_ok) begin
						unique case (pend_kind)
							pstc_pkg::PSTC_KIND_LIGHT:    mode <= pstc_pkg::PSTC_LIGHT;
							pstc_pkg::PSTC_KIND_SHUTDOWN: mode <= pstc_pkg::PSTC_OFF;
							default:                      mode <= pstc_pkg::PSTC_DEEP;
						endcase
					end
				end
				pstc_pkg::PSTC_DEEP, pstc_pkg::PSTC_LIGHT: begin
					if (wake_event) begin
						pend_kind  <= pstc_pkg::PSTC_KIND_NONE;
						keep_valid <= 1'b0;
						if (keep_valid) begin
							tgt_sw  <= keep_sw;
							tgt_lvl <= keep_lvl;
							mode    <= pstc_pkg::PSTC_STEP;
							step.go <= 1'b1;
						end else begin
							mode <= pstc_pkg::PSTC_ACTIVE;
						end
					end
				end
				pstc_pkg::PSTC_OFF: begin
					mode <= pstc_pkg::PSTC_OFF;
				end
				default: mode <= pstc_pkg::PSTC_ACTIVE;
			endcase
		end
	end

	// registered pin outputs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			switching_regulator_select <= 1'b0;
			core_level_one             <= 1'b0;
			deep_sleep_entry           <= 1'b0;
			light_sleep_entry          <= 1'b0;
			shutdown_entry             <= 1'b0;
			clock_halt                 <= 1'b0;
			irq                        <= 1'b0;
		end else begin
			switching_regulator_select <= cur_sw;
			core_level_one             <= cur_lvl;
			deep_sleep_entry           <= mode == pstc_pkg::PSTC_DEEP && !cur_sw;
			light_sleep_entry          <= mode == pstc_pkg::PSTC_LIGHT;
			shutdown_entry             <= mode == pstc_pkg::PSTC_OFF;
			clock_halt                 <= mode == pstc_pkg::PSTC_WAIT_CLK && forced_entry_on && clk_request_busy;
			irq                        <= |(flags & mask);
		end
	end
endmodule
`default_nettype wire

// ==== hw/pstc_map.svh ====
// register offsets, field positions, reset values and timing counts of the power sequencer
`ifndef PSTC_MAP_SVH
`define PSTC_MAP_SVH
`define PSTC_OFF_CTRL      12'h000
`define PSTC_OFF_REQ       12'h004
`define PSTC_OFF_STATE     12'h008
`define PSTC_OFF_STATUS    12'h00C
`define PSTC_OFF_MASK      12'h010
`define PSTC_OFF_MASKED    12'h014
`define PSTC_CTRL_FORCED   0
`define PSTC_REQ_KIND_LSB  0
`define PSTC_REQ_ARG_LSB   4
`define PSTC_FLAG_REG_ERR  0
`define PSTC_FLAG_ACT_BAD  1
`define PSTC_FLAG_CLK_BAD  2
`define PSTC_FLAG_SLP_BAD  3
`define PSTC_RST_MASK      4'h0
`define PSTC_STEP_NS       100
`define PSTC_CLK_NS        25
`define PSTC_STEP_CYC      ((`PSTC_STEP_NS + `PSTC_CLK_NS - 1) / `PSTC_CLK_NS)
`endif

// ==== hw/pstc_pkg.sv ====
// types shared by the power sequencer files
package pstc_pkg;
	typedef enum logic [2:0] {
		PSTC_KIND_NONE, PSTC_KIND_STATE, PSTC_KIND_LEVEL, PSTC_KIND_REG,
		PSTC_KIND_SLEEP_KEEP, PSTC_KIND_SLEEP_DIRECT, PSTC_KIND_LIGHT, PSTC_KIND_SHUTDOWN
	} pstc_kind_t;
	typedef enum logic [2:0] {
		PSTC_ACTIVE, PSTC_STEP, PSTC_WAIT_CLK, PSTC_DEEP, PSTC_LIGHT, PSTC_OFF
	} pstc_mode_t;
endpackage

// ==== hw/pstc_step_if.sv ====
// carries one regulator or level step request and its completion
`timescale 1ns/1ps
`default_nettype none
interface pstc_step_if;
	logic go;
	logic done;
	modport ctl (output go, input done);
	modport tmr (input go, output done);
endinterface
`default_nettype wire

// ==== hw/pstc_step_timer.sv ====
// settling timer for one regulator or level step
`timescale 1ns/1ps
`default_nettype none
`include "pstc_map.svh"
module pstc_step_timer (
	input  wire logic ref_clk,
	input  wire logic reset,
	pstc_step_if.tmr  step
);
	localparam int unsigned CYC = `PSTC_STEP_CYC;
	logic [7:0] cnt;
	logic       busy;

	// counts one settling interval after go
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt       <= 8'h00;
			busy      <= 1'b0;
			step.done <= 1'b0;
		end else begin
			step.done <= 1'b0;
			// a new go restarts the count so a stale interval never ends a fresh step early
			if (step.go) begin
				busy <= 1'b1;
				cnt  <= 8'(CYC - 1);
			end else if (busy) begin
				if (cnt == 8'h00) begin
					busy      <= 1'b0;
					step.done <= 1'b1;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/pstc_properties.sv ====
// port assertions for the power sequencer
`timescale 1ns/1ps
`default_nettype none
module pstc_properties (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic switching_regulator_select,
	input wire logic core_level_one,
	input wire logic deep_sleep_entry,
	input wire logic light_sleep_entry,
	input wire logic shutdown_entry,
	input wire logic clock_halt,
	input wire logic irq
);
	// short aliases of the state outputs
	wire logic sw   = switching_regulator_select;
	wire logic lvl  = core_level_one;
	wire logic deep = deep_sleep_entry;
	// one clock domain, checks off in reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_reset_linear: assert property ($fell(reset) |-> !sw && !lvl && !irq)
		else $error("state not linear level zero after reset");
	chk_one_field: assert property (!$stable(sw) |-> $stable(lvl))
		else $error("regulator and level changed together");
	chk_deep_linear: assert property (deep |-> !sw)
		else $error("deep sleep with switching regulator");
	chk_sleep_still: assert property (deep && $past(deep) |-> $stable({sw, lvl}))
		else $error("state moved during deep sleep");
	chk_sleep_onehot: assert property ($onehot0({deep, light_sleep_entry, shutdown_entry}))
		else $error("two sleep states at once");
	chk_shut_final: assert property (shutdown_entry |=> shutdown_entry)
		else $error("shutdown left without reset");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_pready_wait: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("pready not one cycle after access");
	// main scenarios
	cover property ($rose(deep));
	cover property ($rose(clock_halt));
	cover property ($rose(irq));
endmodule
bind pstc_top pstc_properties i_chk (.ref_clk, .reset, .psel, .penable, .pready, .switching_regulator_select,
	.core_level_one, .deep_sleep_entry, .light_sleep_entry, .shutdown_entry, .clock_halt, .irq);
`default_nettype wire

// ==== bench/pstc_partner.sv ====
// clock requesters, wake source and regulator outside the sequencer
`timescale 1ns/1ps
`default_nettype none
module pstc_partner (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic busy_cmd,
	input  wire logic wake_cmd,
	input  wire logic fault_cmd,
	output logic      clk_request_busy,
	output logic      wake_event,
	output logic      regulator_fault
);
	// requesters follow their commands one cycle late
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clk_request_busy <= 1'b0;
			wake_event       <= 1'b0;
			regulator_fault  <= 1'b0;
		end else begin
			clk_request_busy <= busy_cmd;
			wake_event       <= wake_cmd;
			regulator_fault  <= fault_cmd;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        busy_cmd = 1'b0, wake_cmd = 1'b0, fault_cmd = 1'b0, err;
	logic        ref_clk, pready, pslverr, busy, wake, fault, sw, lvl, deep, halt, irq;
	int          miscompares = 0, checks_done = 0;
	// far side and design
	pstc_partner i_far (.ref_clk, .reset, .busy_cmd, .wake_cmd, .fault_cmd,
		.clk_request_busy(busy), .wake_event(wake), .regulator_fault(fault));
	pstc_top i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.clk_request_busy(busy), .wake_event(wake), .regulator_fault(fault), .switching_regulator_select(sw),
		.core_level_one(lvl), .deep_sleep_entry(deep), .light_sleep_entry(), .shutdown_entry(),
		.clock_halt(halt), .irq);
	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic req(input logic [2:0] k, input logic [3:0] g);
		wr(12'h004, {24'h0, g, 1'b0, k});
	endtask
	// poll the state register until it shows the expected value
	task automatic wst(input logic [31:0] e, input logic [31:0] m);
		logic [31:0] r;
		for (int i = 0; i < 30; i++) begin
			apb(1'b0, 12'h008, 32'h0, r);
			if ((r & m) === e) break;
		end
		chk(r & m, e);
	endtask
	task automatic wk();
		@(posedge ref_clk);
		wake_cmd <= 1'b1;
		@(posedge ref_clk);
		wake_cmd <= 1'b0;
	endtask
	task automatic t_moves();
		chk({sw, lvl}, 2'b00);
		rdc(12'h010, 32'h0);
		req(3'd1, 4'h3);
		for (int i = 0; i < 40 && sw !== 1'b1; i++) @(posedge ref_clk);
		chk(lvl, 1'b1);
		wst(32'h03, 32'h73);
		req(3'd2, 4'h0);
		wst(32'h02, 32'h73);
		req(3'd3, 4'h0);
		wst(32'h00, 32'h73);
	endtask
	task automatic t_sleep();
		req(3'd3, 4'h1);
		wst(32'h02, 32'h73);
		req(3'd4, 4'h0);
		wst(32'h30, 32'h73);
		wk();
		wst(32'h02, 32'h73);
		req(3'd5, 4'h0);
		rdc(12'h00C, 32'h8);
		req(3'd3, 4'h0);
		wst(32'h00, 32'h73);
		req(3'd5, 4'h0);
		wst(32'h30, 32'h7B);
		wk();
		req(3'd6, 4'h0);
		wst(32'h40, 32'h73);
		wk();
		wst(32'h00, 32'h73);
	endtask
	task automatic t_clocks(input logic forced);
		logic seen;
		seen = 1'b0;
		wr(12'h000, {31'h0, forced});
		busy_cmd <= 1'b1;
		req(3'd4, 4'h0);
		for (int i = 0; i < 40 && deep !== 1'b1; i++) begin
			@(posedge ref_clk);
			seen = seen | halt;
		end
		chk({seen, deep}, {forced, forced});
		if (!forced) begin
			req(3'd2, 4'h0);
			rdc(12'h00C, 32'h6);
		end
		busy_cmd <= 1'b0;
		wst(32'h30, 32'h73);
		wk();
		wst(32'h00, 32'h73);
		wr(12'h000, 32'h0);
	endtask
	task automatic t_flags();
		wr(12'h00C, 32'h0);
		rdc(12'h00C, 32'h0);
		req(3'd0, 4'h0);
		rdc(12'h014, 32'h0);
		chk(irq, 1'b0);
		wr(12'h010, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		rdc(12'h00C, 32'h2);
		rdc(12'h00C, 32'h0);
		chk(irq, 1'b0);
		fault_cmd <= 1'b1;
		@(posedge ref_clk);
		fault_cmd <= 1'b0;
		rdc(12'h00C, 32'h1);
		rdc(12'h020, 32'h0);
		chk(err, 1'b1);
		req(3'd7, 4'h0);
		req(3'd1, 4'h3);
		wst(32'h50, 32'h73);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_moves();
		t_sleep();
		t_clocks(1'b0);
		t_clocks(1'b1);
		t_flags();
		finish_test();
	end
endmodule
`default_nettype wire
